/* include/fault_cfg_pkg.sv */
// Constants, field layouts and carriers of the motor fault configuration bank
package fault_cfg_pkg;
  // ==========================================================
  // Register indices, byte address is four times the index
  localparam logic [9:0] IDX_PRIMARY = 10'h091;
  localparam logic [9:0] IDX_SECONDARY = 10'h092;
  localparam logic [9:0] IDX_STATUS = 10'h0A0;
  localparam logic [9:0] IDX_MASK = 10'h0A1;
  localparam logic [9:0] IDX_CONTROL = 10'h0A2;
  localparam logic [31:0] RST_WORD = 32'h0000_0000;
  localparam int CTRL_CLEAR_BIT = 0;
  // ==========================================================
  // Status bit positions
  localparam int ST_LOCK = 0;
  localparam int ST_TIMEOUT = 1;
  localparam int ST_FREQ = 2;
  localparam int ST_SAT = 3;
  localparam int ST_W = 4;
  // ==========================================================
  // Lock action codes
  localparam logic [3:0] ACT_LAST_LATCH = 4'h7;
  localparam logic [3:0] ACT_REPORT = 4'h8;
  localparam logic [3:0] ACT_FIRST_OFF = 4'h9;
  localparam logic [1:0] GATE_HIZ = 2'h0;
  localparam logic [1:0] GATE_RECIRC = 2'h1;
  localparam logic [1:0] GATE_BRAKE_HIGH = 2'h2;
  localparam logic [1:0] GATE_BRAKE_LOW = 2'h3;
  // ==========================================================
  // Trip level decoding
  localparam logic [7:0] OVERSPEED_BASE_PCT = 8'h82;
  localparam logic [7:0] BACKEMF_BASE_PCT = 8'h0A;
  localparam logic [7:0] LEVEL_STEP_PCT = 8'h0A;
  localparam logic [9:0] ABSENT_MA [8] = '{10'h032, 10'h04B, 10'h064, 10'h07D,
                                           10'h0FA, 10'h1F4, 10'h2EE, 10'h3E8};
  // ==========================================================
  // Register layouts
  typedef struct packed {
    logic [24:0] upper;
    logic [3:0] lock_action_select;
    logic position_detect_timeout_fault_on;
    logic position_detect_freq_fault_on;
    logic saturation_report_on;
  } primary_t;
  typedef struct packed {
    logic parity;
    logic overspeed_lock_on;
    logic backemf_lock_on;
    logic absent_motor_lock_on;
    logic [2:0] overspeed_trip_level;
    logic [2:0] backemf_trip_level;
    logic [2:0] absent_motor_current_level;
    logic [18:0] lower;
  } secondary_t;
  typedef struct packed {
    logic hiz;
    logic recirc;
    logic brake_high;
    logic brake_low;
  } gate_action_t;
endpackage

/* logic/motor_fault_config_bank.sv */
// AHB-Lite register bank with lock, detection fault and saturation handling
`timescale 1ns/1ps
module motor_fault_config_bank (
  input wire logic clock,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic overspeed_hit,
  input wire logic backemf_hit,
  input wire logic absent_motor_hit,
  input wire logic position_timeout_evt,
  input wire logic position_freq_evt,
  input wire logic current_loop_sat,
  input wire logic speed_loop_sat,
  output logic fault_out_n,
  output fault_cfg_pkg::gate_action_t gate_action,
  output logic saturation_flag,
  output logic [7:0] overspeed_trip_pct,
  output logic [7:0] backemf_trip_pct,
  output logic [9:0] absent_motor_ma,
  output logic irq
);
  import fault_cfg_pkg::*;

  // ==========================================================
  // Bus slave
  logic wr_pend_q;
  logic [9:0] wr_idx_q;
  logic addr_take;
  logic [9:0] addr_idx;
  logic status_read;
  logic [31:0] rd_word;
  primary_t prim_q;
  secondary_t sec_q;
  logic [ST_W-1:0] stat_q;
  logic [ST_W-1:0] mask_q;
  logic [ST_W-1:0] stat_set;
  logic fault_clear;

  assign addr_take = hsel && htrans[1] && hready;
  assign addr_idx = haddr[11:2];
  assign status_read = ce && addr_take && !hwrite && (addr_idx == IDX_STATUS);
  assign fault_clear = ce && wr_pend_q && (wr_idx_q == IDX_CONTROL) && hwdata[CTRL_CLEAR_BIT];

  // Zero wait states: hreadyout rises on the first edge after reset and then holds, hresp never moves
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hreadyout <= 1'b0;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      wr_pend_q <= 1'b0;
      wr_idx_q <= '0;
    end else if (ce) begin
      wr_pend_q <= addr_take && hwrite;
      wr_idx_q <= addr_idx;
    end
  end

  always_comb begin
    rd_word = RST_WORD;
    unique case (addr_idx)
      IDX_PRIMARY: rd_word = prim_q;
      IDX_SECONDARY: rd_word = sec_q;
      IDX_STATUS: rd_word[ST_W-1:0] = stat_q;
      IDX_MASK: rd_word[ST_W-1:0] = mask_q;
      default: rd_word = RST_WORD;
    endcase
  end

  // Read data is prepared in the address phase, unmapped words read zero
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      hrdata <= '0;
    end else if (ce && addr_take && !hwrite) begin
      hrdata <= rd_word;
    end
  end

  // ==========================================================
  // Configuration words
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      prim_q <= RST_WORD;
    end else if (ce && wr_pend_q && wr_idx_q == IDX_PRIMARY) begin
      prim_q <= hwdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      sec_q <= RST_WORD;
    end else if (ce && wr_pend_q && wr_idx_q == IDX_SECONDARY) begin
      sec_q <= hwdata;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      mask_q <= '0;
    end else if (ce && wr_pend_q && wr_idx_q == IDX_MASK) begin
      mask_q <= hwdata[ST_W-1:0];
    end
  end

  // ==========================================================
  // Lock detection
  logic lock_hit;
  logic lock_off;
  logic lock_latch_q;
  logic lock_report_q;
  logic [1:0] action_q;
  logic lock_new;
  logic [3:0] act;

  assign act = prim_q.lock_action_select;
  assign lock_off = act >= ACT_FIRST_OFF;
  assign lock_hit = !lock_off && ((overspeed_hit && sec_q.overspeed_lock_on) ||
                    (backemf_hit && sec_q.backemf_lock_on) ||
                    (absent_motor_hit && sec_q.absent_motor_lock_on));
  assign lock_new = ce && lock_hit && !lock_latch_q && !lock_report_q;

  // Codes 4 to 7 keep the gate action of their low two bits; retry is not modelled
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lock_latch_q <= 1'b0;
      action_q <= GATE_HIZ;
    end else if (ce) begin
      if (lock_new && act <= ACT_LAST_LATCH) begin
        lock_latch_q <= 1'b1;
        action_q <= act[1:0];
      end else if (fault_clear) begin
        lock_latch_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      lock_report_q <= 1'b0;
    end else if (ce) begin
      if (lock_new && act == ACT_REPORT) begin
        lock_report_q <= 1'b1;
      end else if (fault_clear) begin
        lock_report_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      gate_action <= '0;
    end else if (ce) begin
      gate_action.hiz <= lock_latch_q && action_q == GATE_HIZ;
      gate_action.recirc <= lock_latch_q && action_q == GATE_RECIRC;
      gate_action.brake_high <= lock_latch_q && action_q == GATE_BRAKE_HIGH;
      gate_action.brake_low <= lock_latch_q && action_q == GATE_BRAKE_LOW;
    end
  end

  // ==========================================================
  // Position detection faults and saturation
  logic pd_fault_q;
  logic pd_hit;
  logic sat_hit;

  assign pd_hit = (position_timeout_evt && prim_q.position_detect_timeout_fault_on) ||
                  (position_freq_evt && prim_q.position_detect_freq_fault_on);
  assign sat_hit = prim_q.saturation_report_on && (current_loop_sat || speed_loop_sat);

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      pd_fault_q <= 1'b0;
    end else if (ce) begin
      if (pd_hit) begin
        pd_fault_q <= 1'b1;
      end else if (fault_clear) begin
        pd_fault_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      saturation_flag <= 1'b0;
    end else if (ce) begin
      saturation_flag <= sat_hit;
    end
  end

  // Fault pin follows the latches one cycle later
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      fault_out_n <= 1'b1;
    end else if (ce) begin
      fault_out_n <= !(lock_latch_q || lock_report_q || pd_fault_q);
    end
  end

  // ==========================================================
  // Status and interrupt
  assign stat_set[ST_LOCK] = lock_new && act <= ACT_REPORT;
  assign stat_set[ST_TIMEOUT] = position_timeout_evt && prim_q.position_detect_timeout_fault_on;
  assign stat_set[ST_FREQ] = position_freq_evt && prim_q.position_detect_freq_fault_on;
  assign stat_set[ST_SAT] = sat_hit;

  // A set in the same cycle as the clearing read wins
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      stat_q <= '0;
    end else if (ce) begin
      stat_q <= (status_read ? '0 : stat_q) | stat_set;
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      irq <= 1'b0;
    end else if (ce) begin
      irq <= |(stat_q & mask_q);
    end
  end

  // ==========================================================
  // Trip level decoding
  function automatic logic [7:0] pct(input logic [7:0] base, input logic [2:0] code);
    pct = base + 8'(LEVEL_STEP_PCT * code);
  endfunction

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      overspeed_trip_pct <= '0;
      backemf_trip_pct <= '0;
      absent_motor_ma <= '0;
    end else if (ce) begin
      overspeed_trip_pct <= pct(OVERSPEED_BASE_PCT, sec_q.overspeed_trip_level);
      backemf_trip_pct <= pct(BACKEMF_BASE_PCT, sec_q.backemf_trip_level);
      absent_motor_ma <= ABSENT_MA[sec_q.absent_motor_current_level];
    end
  end

  // ==========================================================
  // Checks
  sequence sec_write_s;
    ce && wr_pend_q && wr_idx_q == IDX_SECONDARY;
  endsequence

  sequence lock_trip_s;
    lock_new && act < GATE_BRAKE_LOW + 4'h1;
  endsequence

  sequence pin_low_s;
    lock_latch_q ##1 !fault_out_n;
  endsequence

  timeout_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    $rose(stat_q[ST_TIMEOUT]) && !$past(position_freq_evt) |-> $past(prim_q.position_detect_timeout_fault_on))
    else $error("timeout fault raised while disabled");

  freq_gate_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && position_freq_evt && prim_q.position_detect_freq_fault_on |=> stat_q[ST_FREQ] && pd_fault_q)
    else $error("frequency fault not raised");

  sat_flag_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && !prim_q.saturation_report_on |=> !saturation_flag)
    else $error("saturation shown while disabled");

  sec_store_a: assert property (@(posedge clock) disable iff (!nrst)
    sec_write_s |=> sec_q == $past(hwdata))
    else $error("secondary word not stored");

  overspeed_lock_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && overspeed_hit && sec_q.overspeed_lock_on && act <= ACT_REPORT |=> lock_latch_q || lock_report_q)
    else $error("overspeed lock missed");

  backemf_lock_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && backemf_hit && sec_q.backemf_lock_on && act <= ACT_REPORT |=> lock_latch_q || lock_report_q)
    else $error("back-EMF lock missed");

  absent_lock_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && absent_motor_hit && sec_q.absent_motor_lock_on && act <= ACT_REPORT |=> lock_latch_q || lock_report_q)
    else $error("absent motor lock missed");

  overspeed_level_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && nrst |=> overspeed_trip_pct == 8'(OVERSPEED_BASE_PCT + LEVEL_STEP_PCT * $past(sec_q.overspeed_trip_level)))
    else $error("overspeed level wrong");

  backemf_level_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && nrst |=> backemf_trip_pct == 8'(BACKEMF_BASE_PCT + LEVEL_STEP_PCT * $past(sec_q.backemf_trip_level)))
    else $error("back-EMF level wrong");

  absent_level_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && nrst |=> absent_motor_ma == ABSENT_MA[$past(sec_q.absent_motor_current_level)])
    else $error("absent motor current wrong");

  lock_pin_a: assert property (@(posedge clock) disable iff (!nrst)
    lock_trip_s ##1 ce |-> pin_low_s)
    else $error("latched lock without fault pin");

  report_only_a: assert property (@(posedge clock) disable iff (!nrst)
    lock_new && act == ACT_REPORT |=> lock_report_q && !lock_latch_q ##1 (ce -> gate_action == '0))
    else $error("report mode took gate action");

  lock_off_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && lock_off |=> !$rose(lock_latch_q) && !$rose(lock_report_q))
    else $error("lock raised while detection off");

  parity_inert_a: assert property (@(posedge clock) disable iff (!nrst)
    sec_write_s ##1 $changed(sec_q.parity) |-> $stable(fault_out_n) && $stable(gate_action))
    else $error("parity bit had an effect");

  disabled_quiet_a: assert property (@(posedge clock) disable iff (!nrst)
    ce && !sec_q.overspeed_lock_on && !sec_q.backemf_lock_on && !sec_q.absent_motor_lock_on
    |=> !$rose(lock_latch_q) && !$rose(lock_report_q))
    else $error("disabled detector raised a lock");

  // Zero wait: a stall or error here would hang every bus master
  bus_okay_a: assert property (@(posedge clock) disable iff (!nrst)
    nrst |=> hreadyout && !hresp)
    else $error("bus stalled or answered with error");

  status_clear_a: assert property (@(posedge clock) disable iff (!nrst)
    status_read && !stat_set[ST_TIMEOUT] |=> !stat_q[ST_TIMEOUT])
    else $error("timeout status survived its read");

  lock_status_a: assert property (@(posedge clock) disable iff (!nrst)
    lock_trip_s |=> stat_q[ST_LOCK])
    else $error("lock not recorded in status");

endmodule

/* testbench/motor_fault_config_bank_tb.sv */
// Self-checking testbench for the motor fault configuration bank
`timescale 1ns/1ps
module motor_fault_config_bank_tb;
  import fault_cfg_pkg::*;
  // ==========================================================
  // Stimulus and observation signals
  logic clock, nrst, ce, hsel, hwrite, hreadyout, hresp, fault_out_n, saturation_flag, irq;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [2:0] hit;
  logic timeout_evt, freq_evt, cur_sat, spd_sat;
  gate_action_t gate_action;
  logic [7:0] overspeed_trip_pct, backemf_trip_pct;
  logic [9:0] absent_motor_ma;
  int fails, total_checks, cycles;
  logic [9:0] ma_table [8] = '{10'h032, 10'h04B, 10'h064, 10'h07D, 10'h0FA, 10'h1F4, 10'h2EE, 10'h3E8};

  motor_fault_config_bank uut (
    .clock(clock), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .overspeed_hit(hit[0]), .backemf_hit(hit[1]),
    .absent_motor_hit(hit[2]), .position_timeout_evt(timeout_evt), .position_freq_evt(freq_evt),
    .current_loop_sat(cur_sat), .speed_loop_sat(spd_sat), .fault_out_n(fault_out_n),
    .gate_action(gate_action), .saturation_flag(saturation_flag),
    .overspeed_trip_pct(overspeed_trip_pct), .backemf_trip_pct(backemf_trip_pct),
    .absent_motor_ma(absent_motor_ma), .irq(irq)
  );

  // ==========================================================
  // Clock, reset and hang guard
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 6000) begin
      fails = fails + 1;
      $display("Timeout after %0d cycles", cycles);
      results();
    end
  end

  // ==========================================================
  // Shared tasks
  function automatic logic [31:0] addr_of(input logic [9:0] idx);
    return {20'h0, idx, 2'b00};
  endfunction

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks = total_checks + 1;
    if (seen !== exp) begin
      fails = fails + 1;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Address phase is held until hready, then data phase until hready again
  task automatic bus(input logic [9:0] idx, input logic wr, input logic [31:0] wdata);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= addr_of(idx);
    hwrite <= wr;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wr ? wdata : 32'h0000_0000;
    @(posedge clock);
    while (hreadyout !== 1'b1) @(posedge clock);
    rd = hrdata;
  endtask

  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    bus(idx, 1'b1, d);
  endtask

  task automatic rd_check(input string what, input logic [9:0] idx, input logic [31:0] exp);
    bus(idx, 1'b0, 32'h0000_0000);
    check(what, rd, exp);
  endtask

  // Settle three edges so registered outputs have landed
  task automatic settle();
    repeat (3) @(posedge clock);
    #1;
  endtask

  task automatic pulse(input int which);
    @(posedge clock);
    if (which < 3) hit[which] <= 1'b1;
    if (which == 3) timeout_evt <= 1'b1;
    if (which == 4) freq_evt <= 1'b1;
    @(posedge clock);
    hit <= 3'h0;
    timeout_evt <= 1'b0;
    freq_evt <= 1'b0;
    settle();
  endtask

  task automatic clear_faults();
    wr(IDX_CONTROL, 32'h0000_0001);
    settle();
    check("fault_out_n cleared", {31'h0, fault_out_n}, 32'h1);
    check("gate cleared", {28'h0, gate_action}, 32'h0);
  endtask

  task automatic end_test(input string name);
    $display("Test %s done, checks %0d, mismatches %0d", name, total_checks, fails);
  endtask

  task automatic results();
    $display("Checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    fails = 0;
    total_checks = 0;
    cycles = 0;
    nrst = 1'b0;
    ce = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0000_0000;
    hit = 3'h0;
    timeout_evt = 1'b0;
    freq_evt = 1'b0;
    cur_sat = 1'b0;
    spd_sat = 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    // Reset values and plain storage
    rd_check("primary reset", IDX_PRIMARY, 32'h0000_0000);
    rd_check("secondary reset", IDX_SECONDARY, 32'h0000_0000);
    check("fault_out_n idle", {31'h0, fault_out_n}, 32'h1);
    wr(IDX_SECONDARY, 32'hFFFF_FFFF);
    rd_check("secondary ones", IDX_SECONDARY, 32'hFFFF_FFFF);
    wr(IDX_SECONDARY, 32'h8000_0000);
    rd_check("parity alone", IDX_SECONDARY, 32'h8000_0000);
    check("parity no fault", {31'h0, fault_out_n}, 32'h1);
    wr(IDX_PRIMARY, 32'h0000_0007);
    rd_check("primary enables", IDX_PRIMARY, 32'h0000_0007);
    rd_check("unmapped reads zero", 10'h3F0, 32'h0000_0000);
    end_test("registers");
    // Every code of the three trip fields
    for (int k = 0; k < 8; k++) begin
      wr(IDX_SECONDARY, {4'h0, 3'(k), 3'(7 - k), 3'(k), 19'h0});
      settle();
      check("overspeed pct", {24'h0, overspeed_trip_pct}, 32'(130 + 10 * k));
      check("backemf pct", {24'h0, backemf_trip_pct}, 32'(10 + 10 * (7 - k)));
      check("absent ma", {22'h0, absent_motor_ma}, {22'h0, ma_table[k]});
    end
    end_test("trip levels");
    // Position faults, interrupt raise, mask and clear-on-read
    wr(IDX_MASK, 32'h0000_0002);
    wr(IDX_PRIMARY, 32'h0000_0004);
    pulse(3);
    check("timeout fault pin", {31'h0, fault_out_n}, 32'h0);
    check("irq raised", {31'h0, irq}, 32'h1);
    rd_check("status timeout", IDX_STATUS, 32'h0000_0002);
    settle();
    check("irq after read", {31'h0, irq}, 32'h0);
    clear_faults();
    wr(IDX_PRIMARY, 32'h0000_0002);
    pulse(3);
    check("timeout off", {31'h0, fault_out_n}, 32'h1);
    pulse(4);
    check("freq fault pin", {31'h0, fault_out_n}, 32'h0);
    check("freq masked irq", {31'h0, irq}, 32'h0);
    rd_check("status freq", IDX_STATUS, 32'h0000_0004);
    clear_faults();
    wr(IDX_PRIMARY, 32'h0000_0000);
    pulse(4);
    check("freq off", {31'h0, fault_out_n}, 32'h1);
    wr(IDX_MASK, 32'h0000_0000);
    end_test("position faults");
    // Saturation indication
    @(posedge clock);
    cur_sat <= 1'b1;
    settle();
    check("sat disabled", {31'h0, saturation_flag}, 32'h0);
    wr(IDX_PRIMARY, 32'h0000_0001);
    settle();
    check("sat current", {31'h0, saturation_flag}, 32'h1);
    @(posedge clock);
    cur_sat <= 1'b0;
    spd_sat <= 1'b1;
    settle();
    check("sat speed", {31'h0, saturation_flag}, 32'h1);
    @(posedge clock);
    spd_sat <= 1'b0;
    settle();
    check("sat gone", {31'h0, saturation_flag}, 32'h0);
    rd_check("status saturation", IDX_STATUS, 32'h0000_0008);
    end_test("saturation");
    // Lock actions 0 to 3 across the three detectors
    for (int a = 0; a < 4; a++) begin
      wr(IDX_PRIMARY, {25'h0, 4'(a), 3'h0});
      wr(IDX_SECONDARY, 32'h4000_0000 >> (a % 3));
      pulse(a % 3);
      check("lock pin", {31'h0, fault_out_n}, 32'h0);
      check("lock gate", {28'h0, gate_action}, {28'h0, 4'h8 >> a});
      clear_faults();
    end
    // Report only, then disabled action
    wr(IDX_PRIMARY, {25'h0, ACT_REPORT, 3'h0});
    wr(IDX_SECONDARY, 32'h7000_0000);
    pulse(1);
    check("report pin", {31'h0, fault_out_n}, 32'h0);
    check("report gate", {28'h0, gate_action}, 32'h0);
    clear_faults();
    wr(IDX_PRIMARY, {25'h0, ACT_FIRST_OFF, 3'h0});
    pulse(2);
    check("action 9 off", {31'h0, fault_out_n}, 32'h1);
    wr(IDX_PRIMARY, {25'h0, 4'hF, 3'h0});
    pulse(0);
    check("action 15 off", {31'h0, fault_out_n}, 32'h1);
    // Disabled back-EMF and absent motor detectors stay quiet at trip code 7
    wr(IDX_PRIMARY, 32'h0000_0000);
    wr(IDX_SECONDARY, 32'h4FF8_0000);
    pulse(1);
    pulse(2);
    check("disabled detectors", {31'h0, fault_out_n}, 32'h1);
    check("disabled gate", {28'h0, gate_action}, 32'h0);
    end_test("lock");
    // Mid-run reset returns both words to zero
    @(posedge clock);
    nrst <= 1'b0;
    repeat (3) @(posedge clock);
    nrst <= 1'b1;
    rd_check("secondary after reset", IDX_SECONDARY, 32'h0000_0000);
    rd_check("primary after reset", IDX_PRIMARY, 32'h0000_0000);
    check("overspeed after reset", {24'h0, overspeed_trip_pct}, 32'(130));
    end_test("reset");
    results();
  end
endmodule
